// ### common/rsdfp_pkg.sv
// Purpose: shared constants and types for the rtu master query engine
// Assumes: byte framing and error check are added by the serial layer
// Notes: counts and codes used by the logic live here, except the HIGHEST_OUTPUT and HIGHEST_REGISTER limits
package rsdfp_pkg;
    // Function codes
    localparam logic [7:0] FN_LOOP = 8'h08;
    localparam logic [7:0] FN_FORCE = 8'h0f;
    localparam logic [7:0] FN_PRESET = 8'h10;
    // Loopback diagnostic codes, broadcast address and fill bytes
    localparam logic [15:0] DG_ECHO = 16'h0000;
    localparam logic [15:0] DG_RESTART = 16'h0001;
    localparam logic [15:0] DG_LISTEN = 16'h0004;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hff;
    // Field limits
    localparam logic [15:0] REG_CNT_MIN = 16'h0001;
    localparam logic [15:0] REG_CNT_MAX = 16'h007d;
    localparam logic [15:0] PTS_CNT_MAX = 16'h0800;
    localparam logic [16:0] PTS_ROUND = 17'h00007;
    localparam int PTS_SHIFT = 3;
    // Frame byte positions
    localparam logic [2:0] HDR_LAST = 3'h5;
    localparam logic [2:0] BC_IDX = 3'h6;
    localparam logic [2:0] IDX_DATA = 3'h7;
    localparam logic [8:0] REM_ONE = 9'h001;
    // Payload buffer
    localparam int PAY_W = 8;
    localparam int PAY_DEPTH = 16;
    // Response timeout
    localparam int CLK_PERIOD_NS = 4;
    localparam int RSP_TIMEOUT_US = 100;
    localparam int RSP_TIMEOUT_CYC = RSP_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int TMO_W = 24;

    typedef enum logic [2:0] {
        K_ECHO = 3'h0,
        K_RESTART = 3'h1,
        K_LISTEN = 3'h2,
        K_FORCE = 3'h3,
        K_PRESET = 3'h4
    } rsdfp_kind_t;

    typedef struct packed {
        rsdfp_kind_t kind;
        logic [7:0] addr;
        logic [7:0] first_data_byte;
        logic [7:0] second_data_byte;
        logic [15:0] start;
        logic [15:0] count;
    } rsdfp_cmd_t;

    typedef enum logic [2:0] {
        RES_NONE = 3'h0,
        RES_OK = 3'h1,
        RES_NORSP = 3'h2,
        RES_REFUSED = 3'h3,
        RES_RSP_ERR = 3'h4,
        RES_TIMEOUT = 3'h5
    } rsdfp_res_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SEND = 3'h1,
        ST_FLUSH = 3'h2,
        ST_WAIT = 3'h3
    } rsdfp_state_t;
endpackage : rsdfp_pkg

// ### dv/rsdfp_master_props.sv
// Purpose: concurrent checks on the query engine ports
// Assumes: take happens on cmd_valid and cmd_ready at one edge
// Notes: broadcast memory kept in a small helper flop
`timescale 1ns/1ps
`default_nettype none
module rsdfp_master_props (
    input wire logic clk,
    input wire logic nrst,
    input wire rsdfp_pkg::rsdfp_cmd_t cmd,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic done,
    input wire rsdfp_pkg::rsdfp_res_t result,
    input wire logic slave_quiet
);
    logic take;
    logic ok_rst;
    logic bc_ff;
    // Take and legal restart data
    assign take = cmd_valid && cmd_ready;
    assign ok_rst = cmd.first_data_byte inside {8'h00, 8'hff} && cmd.second_data_byte == 8'h00;
    // Frame in flight is broadcast
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            bc_ff <= 1'b0;
        else if (take)
            bc_ff <= (cmd.addr == 8'h00);
    end
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    echo_bcast_a: assert property (take && cmd.kind == rsdfp_pkg::K_ECHO && cmd.addr == 8'h00
        |-> ##[1:2] done && result == rsdfp_pkg::RES_REFUSED) else $error("broadcast echo not refused");
    restart_refuse_a: assert property (take && cmd.kind == rsdfp_pkg::K_RESTART && !ok_rst
        |-> ##[1:2] done && result == rsdfp_pkg::RES_REFUSED) else $error("bad restart not refused");
    preset_range_a: assert property (take && cmd.kind == rsdfp_pkg::K_PRESET &&
        (cmd.count < 16'h0001 || cmd.count > 16'h007d) |-> ##[1:2] done && result == rsdfp_pkg::RES_REFUSED)
        else $error("bad preset count not refused");
    first_byte_a: assert property (take && cmd.kind == rsdfp_pkg::K_ECHO && cmd.addr != 8'h00
        |-> ##2 tx_valid && tx_byte == $past(cmd.addr, 2)) else $error("frame not opened by address");
    listen_set_a: assert property (take && cmd.kind == rsdfp_pkg::K_LISTEN |=> slave_quiet)
        else $error("listen did not set quiet");
    restart_clear_a: assert property (take && cmd.kind == rsdfp_pkg::K_RESTART && ok_rst |=> !slave_quiet)
        else $error("restart did not clear quiet");
    quiet_cause_a: assert property ($changed(slave_quiet) |-> $past(take))
        else $error("quiet changed without a command");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(tx_last))
        else $error("tx byte changed before accept");
    bcast_quiet_a: assert property (tx_valid && tx_ready && tx_last && bc_ff
        |-> ##[1:2] done && result == rsdfp_pkg::RES_NORSP) else $error("broadcast awaited a reply");
endmodule : rsdfp_master_props
bind rsdfp_master rsdfp_master_props u_props (.clk(clk), .nrst(nrst), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .done(done), .result(result), .slave_quiet(slave_quiet));
`default_nettype wire

// ### dv/rsdfp_slave_model.sv
// Purpose: behavioural slave station answering the master's frames
// Assumes: frame bodies only, no error check bytes
// Notes: err_mode forces an exception reply; slow halves tx acceptance
`timescale 1ns/1ps
`default_nettype none
module rsdfp_slave_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic rx_last,
    input wire logic slow,
    input wire logic err_mode
);
    logic [7:0] q [0:31];
    logic [7:0] r [0:5];
    logic quiet;
    logic bad;
    int n;
    initial begin
        tx_ready = 1'b0;
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        rx_last = 1'b0;
    end
    // One byte a cycle, then invert the idle line
    task automatic reply(input int k);
        for (int i = 0; i < k; i++) begin
            @(posedge clk);
            rx_byte <= r[i];
            rx_valid <= 1'b1;
            rx_last <= (i == k - 1);
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_byte <= ~r[k - 1];
    endtask : reply
    // Collect frame, track listen state, reply if allowed
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            quiet = 1'b0;
            n = 0;
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            if (tx_valid && tx_ready) begin
                if (n < 32)
                    q[n] = tx_byte;
                n++;
                if (tx_last) begin
                    n = 0;
                    bad = err_mode;
                    if (q[1] == 8'h08 && q[3] == 8'h01) begin
                        quiet = 1'b0;
                        bad = bad || !(q[4] inside {8'h00, 8'hff}) || q[5] != 8'h00;
                    end
                    if (q[1] == 8'h08 && q[3] == 8'h04)
                        quiet = 1'b1;
                    if (q[1] == 8'h10 && q[6] != {q[5][6:0], 1'b0})
                        bad = 1'b1;
                    if (q[1] == 8'h0f && q[6] != 8'(({q[4], q[5]} + 16'h0007) >> 3))
                        bad = 1'b1;
                    for (int i = 0; i < 6; i++)
                        r[i] = q[i];
                    r[1] = bad ? (q[1] | 8'h80) : q[1];
                    r[2] = bad ? 8'h03 : q[2];
                    if (q[0] != 8'h00 && !quiet)
                        reply(bad ? 3 : 6);
                end
            end
        end
    end
endmodule : rsdfp_slave_model
`default_nettype wire

// ### dv/testbench.sv
// Purpose: directed scenarios for the query engine against a slave model
// Assumes: reply timeout shortened to 50 cycles
// Notes: frame bytes read back from slave model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    rsdfp_pkg::rsdfp_cmd_t cmd = '0;
    logic cmd_valid = 1'b0, pay_valid = 1'b0, slow = 1'b0, err_mode = 1'b0;
    logic [7:0] pay_data = 8'h00;
    logic cmd_ready, pay_ready, tx_valid, tx_last, tx_ready, rx_valid, rx_last, done, slave_quiet;
    logic [7:0] tx_byte, rx_byte;
    rsdfp_pkg::rsdfp_res_t result;
    int error_cnt = 0;
    int compares = 0;
    always #2 clk = ~clk;
    rsdfp_master #(.RSP_TIMEOUT_CYC(50)) DUT (.clk(clk), .nrst(nrst), .cmd(cmd), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .pay_data(pay_data), .pay_valid(pay_valid), .pay_ready(pay_ready),
        .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rx_last(rx_last), .done(done), .result(result), .slave_quiet(slave_quiet));
    rsdfp_slave_model u_slave (.clk(clk), .nrst(nrst), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_last(rx_last),
        .slow(slow), .err_mode(err_mode));
    task automatic end_sim();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic chk_res(input rsdfp_pkg::rsdfp_res_t got, input rsdfp_pkg::rsdfp_res_t exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t result got %h exp %h", $time, got, exp);
        end
    endtask : chk_res
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t value got %h exp %h", $time, got, exp);
        end
    endtask : chk_val
    // One command, held until taken, judged at its done pulse
    task automatic run(input rsdfp_pkg::rsdfp_kind_t k, input logic [7:0] a, input logic [7:0] d1,
        input logic [7:0] d2, input logic [15:0] s, input logic [15:0] c, input rsdfp_pkg::rsdfp_res_t exp);
        int t;
        @(posedge clk);
        cmd <= '{k, a, d1, d2, s, c};
        cmd_valid <= 1'b1;
        @(posedge clk);
        for (t = 0; t < 100 && cmd_ready !== 1'b1; t++)
            @(posedge clk);
        cmd_valid <= 1'b0;
        for (t = 0; t < 2000 && done !== 1'b1; t++)
            @(posedge clk);
        chk_res(t < 2000 ? result : rsdfp_pkg::RES_NONE, exp);
    endtask : run
    task automatic push(input logic [7:0] b);
        int t;
        @(posedge clk);
        pay_data <= b;
        pay_valid <= 1'b1;
        @(posedge clk);
        for (t = 0; t < 100 && pay_ready !== 1'b1; t++)
            @(posedge clk);
        pay_valid <= 1'b0;
    endtask : push
    task automatic t_echo();
        run(rsdfp_pkg::K_ECHO, 8'h05, 8'h12, 8'h34, 16'h0000, 16'h0000, rsdfp_pkg::RES_OK);
        chk_val(u_slave.q[3], 8'h00);
        err_mode <= 1'b1;
        run(rsdfp_pkg::K_ECHO, 8'h05, 8'h00, 8'hff, 16'h0000, 16'h0000, rsdfp_pkg::RES_RSP_ERR);
        err_mode <= 1'b0;
        $display("t_echo done");
    endtask : t_echo
    task automatic t_refuse();
        run(rsdfp_pkg::K_ECHO, 8'h00, 8'h12, 8'h34, 16'h0000, 16'h0000, rsdfp_pkg::RES_REFUSED);
        run(rsdfp_pkg::K_RESTART, 8'h05, 8'h12, 8'h00, 16'h0000, 16'h0000, rsdfp_pkg::RES_REFUSED);
        run(rsdfp_pkg::K_RESTART, 8'h05, 8'hff, 8'h01, 16'h0000, 16'h0000, rsdfp_pkg::RES_REFUSED);
        u_slave.quiet = 1'b1;
        run(rsdfp_pkg::K_ECHO, 8'h05, 8'h12, 8'h34, 16'h0000, 16'h0000, rsdfp_pkg::RES_TIMEOUT);
        run(rsdfp_pkg::K_RESTART, 8'h05, 8'hff, 8'h00, 16'h0000, 16'h0000, rsdfp_pkg::RES_OK);
        run(rsdfp_pkg::K_PRESET, 8'h05, 8'h00, 8'h00, 16'h0000, 16'h0000, rsdfp_pkg::RES_REFUSED);
        run(rsdfp_pkg::K_PRESET, 8'h05, 8'h00, 8'h00, 16'h0000, 16'h007e, rsdfp_pkg::RES_REFUSED);
        run(rsdfp_pkg::K_FORCE, 8'h05, 8'h00, 8'h00, 16'h0000, 16'h0000, rsdfp_pkg::RES_REFUSED);
        $display("t_refuse done");
    endtask : t_refuse
    task automatic t_listen();
        run(rsdfp_pkg::K_LISTEN, 8'h03, 8'h55, 8'h66, 16'h0000, 16'h0000, rsdfp_pkg::RES_NORSP);
        chk_val(u_slave.q[3] | u_slave.q[4] | u_slave.q[5], 8'h04);
        chk_val({7'h00, slave_quiet}, 8'h01);
        run(rsdfp_pkg::K_ECHO, 8'h03, 8'h12, 8'h34, 16'h0000, 16'h0000, rsdfp_pkg::RES_NORSP);
        run(rsdfp_pkg::K_RESTART, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000, rsdfp_pkg::RES_NORSP);
        run(rsdfp_pkg::K_ECHO, 8'h03, 8'h12, 8'h34, 16'h0000, 16'h0000, rsdfp_pkg::RES_OK);
        run(rsdfp_pkg::K_LISTEN, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000, rsdfp_pkg::RES_NORSP);
        run(rsdfp_pkg::K_RESTART, 8'h03, 8'h00, 8'h00, 16'h0000, 16'h0000, rsdfp_pkg::RES_OK);
        $display("t_listen done");
    endtask : t_listen
    // Mid-run reset restores a responsive slave
    task automatic t_reset();
        run(rsdfp_pkg::K_LISTEN, 8'h03, 8'h00, 8'h00, 16'h0000, 16'h0000, rsdfp_pkg::RES_NORSP);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        chk_val({7'h00, slave_quiet}, 8'h00);
        run(rsdfp_pkg::K_ECHO, 8'h03, 8'h12, 8'h34, 16'h0000, 16'h0000, rsdfp_pkg::RES_OK);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_force();
        push(8'ha5);
        push(8'h03);
        run(rsdfp_pkg::K_FORCE, 8'h09, 8'h00, 8'h00, 16'h0005, 16'h000a, rsdfp_pkg::RES_OK);
        chk_val(u_slave.q[1], 8'h0f);
        chk_val(u_slave.q[3] ^ u_slave.q[5], 8'h0f);
        chk_val(u_slave.q[6], 8'h02);
        chk_val(u_slave.q[7] - u_slave.q[8], 8'ha2);
        push(8'h81);
        run(rsdfp_pkg::K_FORCE, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0008, rsdfp_pkg::RES_NORSP);
        $display("t_force done");
    endtask : t_force
    // Fill buffer until full, drain into slow link
    task automatic t_preset();
        slow <= 1'b1;
        for (int i = 0; i < rsdfp_pkg::PAY_DEPTH; i++)
            push(8'(8'h40 + i));
        @(posedge clk);
        chk_val({7'h00, pay_ready}, 8'h00);
        run(rsdfp_pkg::K_PRESET, 8'h07, 8'h00, 8'h00, 16'h0020, 16'h0008, rsdfp_pkg::RES_OK);
        chk_val(u_slave.q[6], 8'h10);
        for (int i = 0; i < 16; i++)
            chk_val(u_slave.q[7 + i], 8'(8'h40 + i));
        chk_val({7'h00, pay_ready}, 8'h01);
        slow <= 1'b0;
        $display("t_preset done");
    endtask : t_preset
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        t_echo();
        t_refuse();
        t_listen();
        t_reset();
        t_force();
        t_preset();
        end_sim();
    end
    // Few hundred cycles needed; 25000 is ample
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule : testbench
`default_nettype wire

// ### logic/rsdfp_master.sv
// Purpose: master station that issues loopback, force and preset queries
// Assumes: tx/rx byte streams carry frame bodies; error check is external
// Notes: payload bytes for force and preset queries arrive through a FIFO
`timescale 1ns/1ps
`default_nettype none

// Payload buffer with registered ready toward the writer
module rsdfp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic rdy_ff, nxt_rdy;
    logic push, pop;

    assign push = in_valid && rdy_ff;
    assign pop = out_valid && out_ready;
    assign in_ready = rdy_ff;
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem[rd_ff];

    // Pointer and fill bookkeeping
    always_comb begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_wr = (wr_ff == PTR_LAST) ? '0 : wr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rd = (rd_ff == PTR_LAST) ? '0 : rd_ff + 1'b1;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
        // Ready registered from next fill, so it never lies about space
        nxt_rdy = (nxt_cnt != FULL_CNT);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b1;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
        end
    end

    // Storage needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end
endmodule : rsdfp_fifo

module rsdfp_master #(
    parameter logic [15:0] HIGHEST_OUTPUT = 16'h0800,
    parameter logic [15:0] HIGHEST_REGISTER = 16'h0400,
    parameter int RSP_TIMEOUT_CYC = rsdfp_pkg::RSP_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire rsdfp_pkg::rsdfp_cmd_t cmd,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] pay_data,
    input wire logic pay_valid,
    output logic pay_ready,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic rx_last,
    output logic done,
    output rsdfp_pkg::rsdfp_res_t result,
    output logic slave_quiet
);
    localparam logic [rsdfp_pkg::TMO_W-1:0] TMO_LAST = rsdfp_pkg::TMO_W'(RSP_TIMEOUT_CYC - 1);

    // Byte i of the six-byte header, address first
    function automatic logic [7:0] hdr_byte(input logic [47:0] h, input logic [2:0] i);
        logic [7:0] b;
        b = rsdfp_pkg::ZERO_BYTE;
        case (i)
            3'h0: b = h[47:40];
            3'h1: b = h[39:32];
            3'h2: b = h[31:24];
            3'h3: b = h[23:16];
            3'h4: b = h[15:8];
            3'h5: b = h[7:0];
            default: b = rsdfp_pkg::ZERO_BYTE;
        endcase
        return b;
    endfunction : hdr_byte

    // Start below the top and start plus count within it
    function automatic logic out_of_range(input logic [15:0] s, input logic [15:0] n, input logic [15:0] top);
        logic [16:0] sum;
        sum = {1'b0, s} + {1'b0, n};
        return (s >= top) || (sum > {1'b0, top});
    endfunction : out_of_range

    rsdfp_pkg::rsdfp_state_t st_ff, nxt_st;
    rsdfp_pkg::rsdfp_res_t res_ff, nxt_res;
    logic [47:0] hdr_ff, nxt_hdr, new_hdr;
    logic [2:0] idx_ff, nxt_idx, rxn_ff, nxt_rxn;
    logic [8:0] rem_ff, nxt_rem, bc_len;
    logic [7:0] bc_ff, nxt_bc, txb_ff, nxt_txb;
    logic dat_ff, nxt_dat, exp_ff, nxt_exp, quiet_ff, nxt_quiet;
    logic txv_ff, nxt_txv, txl_ff, nxt_txl, rdy_ff, nxt_rdy;
    logic done_ff, nxt_done, mis_ff, nxt_mis, bad, mis_now;
    logic [rsdfp_pkg::TMO_W-1:0] tmo_ff, nxt_tmo;
    logic [16:0] pts_sum;
    logic [7:0] fifo_dat;
    logic fifo_vld, fifo_take;

    rsdfp_fifo #(
        .W(rsdfp_pkg::PAY_W),
        .DEPTH(rsdfp_pkg::PAY_DEPTH)
    ) u_pay (
        .clk(clk),
        .nrst(nrst),
        .in_data(pay_data),
        .in_valid(pay_valid),
        .in_ready(pay_ready),
        .out_data(fifo_dat),
        .out_valid(fifo_vld),
        .out_ready(fifo_take)
    );

    // Data byte count; points round up to whole bytes
    assign pts_sum = {1'b0, cmd.count} + rsdfp_pkg::PTS_ROUND;
    assign bc_len = (cmd.kind == rsdfp_pkg::K_FORCE) ? pts_sum[rsdfp_pkg::PTS_SHIFT+8:rsdfp_pkg::PTS_SHIFT]
                                                     : {cmd.count[7:0], 1'b0};

    // Screen a command before any byte leaves
    always_comb begin
        bad = 1'b1;
        case (cmd.kind)
            rsdfp_pkg::K_ECHO: bad = (cmd.addr == rsdfp_pkg::BCAST_ADDR);
            rsdfp_pkg::K_RESTART: bad = !((cmd.first_data_byte == rsdfp_pkg::ZERO_BYTE) ||
                                          (cmd.first_data_byte == rsdfp_pkg::ALL_ONES)) ||
                                        (cmd.second_data_byte != rsdfp_pkg::ZERO_BYTE);
            rsdfp_pkg::K_LISTEN: bad = 1'b0;
            rsdfp_pkg::K_FORCE: bad = (cmd.count == '0) || (cmd.count > rsdfp_pkg::PTS_CNT_MAX) ||
                                      out_of_range(cmd.start, cmd.count, HIGHEST_OUTPUT);
            rsdfp_pkg::K_PRESET: bad = (cmd.count < rsdfp_pkg::REG_CNT_MIN) ||
                                       (cmd.count > rsdfp_pkg::REG_CNT_MAX) ||
                                       out_of_range(cmd.start, cmd.count, HIGHEST_REGISTER);
            default: bad = 1'b1;
        endcase
    end

    // Header bytes, high byte first in every two-byte field
    always_comb begin
        new_hdr = {cmd.addr, rsdfp_pkg::FN_LOOP, rsdfp_pkg::DG_ECHO,
                   cmd.first_data_byte, cmd.second_data_byte};
        case (cmd.kind)
            rsdfp_pkg::K_RESTART: new_hdr = {cmd.addr, rsdfp_pkg::FN_LOOP, rsdfp_pkg::DG_RESTART,
                                             cmd.first_data_byte, cmd.second_data_byte};
            rsdfp_pkg::K_LISTEN: new_hdr = {cmd.addr, rsdfp_pkg::FN_LOOP, rsdfp_pkg::DG_LISTEN,
                                            rsdfp_pkg::ZERO_BYTE, rsdfp_pkg::ZERO_BYTE};
            rsdfp_pkg::K_FORCE: new_hdr = {cmd.addr, rsdfp_pkg::FN_FORCE, cmd.start, cmd.count};
            rsdfp_pkg::K_PRESET: new_hdr = {cmd.addr, rsdfp_pkg::FN_PRESET, cmd.start, cmd.count};
            default: new_hdr = {cmd.addr, rsdfp_pkg::FN_LOOP, rsdfp_pkg::DG_ECHO,
                                cmd.first_data_byte, cmd.second_data_byte};
        endcase
    end

    // Reply byte compare against the stored header
    assign mis_now = (rxn_ff > rsdfp_pkg::HDR_LAST) || (rx_byte != hdr_byte(hdr_ff, rxn_ff));

    // Query sequencer and reply checker
    always_comb begin
        nxt_st = st_ff;
        nxt_res = res_ff;
        nxt_hdr = hdr_ff;
        nxt_idx = idx_ff;
        nxt_rem = rem_ff;
        nxt_bc = bc_ff;
        nxt_dat = dat_ff;
        nxt_exp = exp_ff;
        nxt_quiet = quiet_ff;
        nxt_txb = txb_ff;
        nxt_txv = txv_ff;
        nxt_txl = txl_ff;
        nxt_rdy = 1'b0;
        nxt_done = 1'b0;
        nxt_tmo = tmo_ff;
        nxt_rxn = rxn_ff;
        nxt_mis = mis_ff;
        fifo_take = 1'b0;
        case (st_ff)
            rsdfp_pkg::ST_IDLE: begin
                nxt_rdy = 1'b1;
                if (cmd_valid && rdy_ff) begin
                    nxt_rdy = 1'b0;
                    if (bad) begin
                        nxt_res = rsdfp_pkg::RES_REFUSED;
                        nxt_done = 1'b1;
                    end else begin
                        nxt_hdr = new_hdr;
                        nxt_idx = '0;
                        nxt_rem = bc_len;
                        nxt_bc = bc_len[7:0];
                        nxt_dat = (cmd.kind == rsdfp_pkg::K_FORCE) || (cmd.kind == rsdfp_pkg::K_PRESET);
                        if (cmd.kind == rsdfp_pkg::K_LISTEN) begin
                            nxt_quiet = 1'b1;
                        end else if (cmd.kind == rsdfp_pkg::K_RESTART) begin
                            nxt_quiet = 1'b0;
                        end
                        // Replies only from an addressed, responsive slave
                        nxt_exp = (cmd.addr != rsdfp_pkg::BCAST_ADDR) &&
                                  (cmd.kind != rsdfp_pkg::K_LISTEN) && !nxt_quiet;
                        nxt_st = rsdfp_pkg::ST_SEND;
                    end
                end
            end
            rsdfp_pkg::ST_SEND: begin
                if (!txv_ff || tx_ready) begin
                    nxt_txv = 1'b0;
                    nxt_txl = 1'b0;
                    if (idx_ff <= rsdfp_pkg::HDR_LAST) begin
                        nxt_txb = hdr_byte(hdr_ff, idx_ff);
                        nxt_txv = 1'b1;
                        nxt_txl = (idx_ff == rsdfp_pkg::HDR_LAST) && !dat_ff;
                        nxt_idx = idx_ff + 3'h1;
                    end else if (idx_ff == rsdfp_pkg::BC_IDX) begin
                        nxt_txb = bc_ff;
                        nxt_txv = 1'b1;
                        nxt_idx = rsdfp_pkg::IDX_DATA;
                    end else if (fifo_vld) begin
                        // Data flows in arrival order; an empty FIFO stalls the frame
                        fifo_take = 1'b1;
                        nxt_txb = fifo_dat;
                        nxt_txv = 1'b1;
                        nxt_txl = (rem_ff == rsdfp_pkg::REM_ONE);
                        nxt_rem = rem_ff - 9'h001;
                    end
                    if (nxt_txl) begin
                        nxt_st = rsdfp_pkg::ST_FLUSH;
                    end
                end
            end
            rsdfp_pkg::ST_FLUSH: begin
                if (tx_ready) begin
                    nxt_txv = 1'b0;
                    nxt_txl = 1'b0;
                    nxt_tmo = '0;
                    nxt_rxn = '0;
                    nxt_mis = 1'b0;
                    if (exp_ff) begin
                        nxt_st = rsdfp_pkg::ST_WAIT;
                    end else begin
                        nxt_res = rsdfp_pkg::RES_NORSP;
                        nxt_done = 1'b1;
                        nxt_st = rsdfp_pkg::ST_IDLE;
                    end
                end
            end
            rsdfp_pkg::ST_WAIT: begin
                nxt_tmo = tmo_ff + 1'b1;
                if (rx_valid) begin
                    nxt_mis = mis_ff || mis_now;
                    if (rxn_ff != rsdfp_pkg::IDX_DATA) begin
                        nxt_rxn = rxn_ff + 3'h1;
                    end
                    if (rx_last) begin
                        // Short, long or differing replies all count as errors
                        nxt_res = (!nxt_mis && (rxn_ff == rsdfp_pkg::HDR_LAST)) ? rsdfp_pkg::RES_OK
                                                                                : rsdfp_pkg::RES_RSP_ERR;
                        nxt_done = 1'b1;
                        nxt_st = rsdfp_pkg::ST_IDLE;
                    end
                end else if (tmo_ff == TMO_LAST) begin
                    nxt_res = rsdfp_pkg::RES_TIMEOUT;
                    nxt_done = 1'b1;
                    nxt_st = rsdfp_pkg::ST_IDLE;
                end
            end
            default: nxt_st = rsdfp_pkg::ST_IDLE;
        endcase
    end

    // Reset leaves the slave assumed responsive
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= rsdfp_pkg::ST_IDLE;
            res_ff <= rsdfp_pkg::RES_NONE;
            hdr_ff <= '0;
            idx_ff <= '0;
            rem_ff <= '0;
            bc_ff <= '0;
            dat_ff <= 1'b0;
            exp_ff <= 1'b0;
            quiet_ff <= 1'b0;
            txb_ff <= '0;
            txv_ff <= 1'b0;
            txl_ff <= 1'b0;
            rdy_ff <= 1'b0;
            done_ff <= 1'b0;
            tmo_ff <= '0;
            rxn_ff <= '0;
            mis_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            res_ff <= nxt_res;
            hdr_ff <= nxt_hdr;
            idx_ff <= nxt_idx;
            rem_ff <= nxt_rem;
            bc_ff <= nxt_bc;
            dat_ff <= nxt_dat;
            exp_ff <= nxt_exp;
            quiet_ff <= nxt_quiet;
            txb_ff <= nxt_txb;
            txv_ff <= nxt_txv;
            txl_ff <= nxt_txl;
            rdy_ff <= nxt_rdy;
            done_ff <= nxt_done;
            tmo_ff <= nxt_tmo;
            rxn_ff <= nxt_rxn;
            mis_ff <= nxt_mis;
        end
    end

    assign cmd_ready = rdy_ff;
    assign tx_byte = txb_ff;
    assign tx_valid = txv_ff;
    assign tx_last = txl_ff;
    assign done = done_ff;
    assign result = res_ff;
    assign slave_quiet = quiet_ff;
endmodule : rsdfp_master

`default_nettype wire
